// ==== core/atcs_pkg.sv ====
package atcs_pkg;

   // ---------------------------------------------------------------
   // register indices and byte addresses
   // ---------------------------------------------------------------
   localparam int ADDR_W = 12;
   localparam logic [7:0] IDX_SC1 = 8'h10;
   localparam logic [7:0] IDX_SC2 = 8'h11;
   localparam logic [7:0] IDX_RESULT = 8'h14;
   localparam logic [7:0] IDX_CMP = 8'h16;
   localparam logic [7:0] IDX_IRQ_STAT = 8'h20;
   localparam logic [7:0] IDX_IRQ_MASK = 8'h21;
   localparam logic [ADDR_W-1:0] ADDR_SC1 = {2'h0, IDX_SC1, 2'h0};
   localparam logic [ADDR_W-1:0] ADDR_SC2 = {2'h0, IDX_SC2, 2'h0};
   localparam logic [ADDR_W-1:0] ADDR_RESULT = {2'h0, IDX_RESULT, 2'h0};
   localparam logic [ADDR_W-1:0] ADDR_CMP = {2'h0, IDX_CMP, 2'h0};
   localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = {2'h0, IDX_IRQ_STAT, 2'h0};
   localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = {2'h0, IDX_IRQ_MASK, 2'h0};

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int BIT_ACTIVE = 7;
   localparam int BIT_TRIG = 6;
   localparam int BIT_CMP_EN = 5;
   localparam int BIT_CMP_GT = 4;
   localparam int BIT_EMPTY = 3;
   localparam int BIT_FULL = 2;
   localparam int BIT_COMPLETE = 7;
   localparam int CHAN_W = 5;
   localparam int IRQ_DONE = 0;
   localparam int IRQ_OVWR = 1;
   localparam int IRQ_W = 2;

   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [CHAN_W-1:0] CHAN_OFF = 5'h1f;
   localparam logic [CHAN_W-1:0] RST_CHAN = 5'h1f;
   localparam logic [7:0] RST_SC2 = 8'h08;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 5;
   localparam int CONV_TIME_NS = 100;
   localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 8;
   localparam int RES_W = 12;
   localparam int FIFO_DEPTH = 4;

   typedef enum logic [1:0] {
      ATCS_IDLE = 2'b01,
      ATCS_CONV = 2'b10
   } atcs_state_t;

endpackage

// ==== core/atcs_result_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none
module atcs_result_fifo #(
   parameter int W = 12,
   parameter int DEPTH = 4
) (
   input wire logic clock,
   input wire logic srst,
   input wire logic flush,
   input wire logic push,
   input wire logic [W-1:0] push_data,
   input wire logic pop,
   output logic [W-1:0] head,
   output logic empty,
   output logic full,
   output logic overwrite
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
   localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

   logic [W-1:0] mem [DEPTH];
   logic [PW-1:0] wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
   logic [CW-1:0] count_r, count_nxt;
   logic do_pop;

   function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
      bump = (p == PTR_LAST) ? '0 : p + 1'b1;
   endfunction

   assign do_pop = pop && (count_r != '0);
   assign empty = (count_r == '0);
   assign full = (count_r == CNT_FULL);
   assign head = mem[rd_ptr_r];
   assign overwrite = push && full && !do_pop && !flush;

   // ---------------------------------------------------------------
   // pointer update
   // ---------------------------------------------------------------
   always_comb
   begin
      wr_ptr_nxt = wr_ptr_r;
      rd_ptr_nxt = rd_ptr_r;
      count_nxt = count_r;
      if (flush)
      begin
         wr_ptr_nxt = '0;
         rd_ptr_nxt = '0;
         count_nxt = '0;
      end
      else
      begin
         if (push)
            wr_ptr_nxt = bump(wr_ptr_r);
         if (do_pop || (push && full))
            rd_ptr_nxt = bump(rd_ptr_r);
         if (push && !do_pop && !full)
            count_nxt = count_r + 1'b1;
         else if (do_pop && !push)
            count_nxt = count_r - 1'b1;
      end
   end

   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
      end
      else
      begin
         wr_ptr_r <= wr_ptr_nxt;
         rd_ptr_r <= rd_ptr_nxt;
         count_r <= count_nxt;
      end
   end

   always_ff @(posedge clock)
   begin
      if (push && !flush)
         mem[wr_ptr_r] <= push_data;
   end

endmodule
`default_nettype wire

// ==== core/atcs_top.sv ====
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module atcs_top #(
   parameter int RES_W = atcs_pkg::RES_W,
   parameter int FIFO_DEPTH = atcs_pkg::FIFO_DEPTH,
   parameter int CONV_CYCLES = atcs_pkg::CONV_CYCLES
) (
   input wire logic clock,
   input wire logic srst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [atcs_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic hardware_trigger_in,
   input wire logic [RES_W-1:0] sample_value,
   output logic conv_start,
   output logic [atcs_pkg::CHAN_W-1:0] conv_channel,
   output logic irq
);
   localparam logic [atcs_pkg::CNT_W-1:0] CNT_LAST = atcs_pkg::CNT_W'(CONV_CYCLES - 1);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   atcs_pkg::atcs_state_t state_r, state_nxt;
   logic [atcs_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
   logic start_r, start_nxt;
   logic [atcs_pkg::CHAN_W-1:0] conv_chan_r, conv_chan_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   logic pready_r, pready_nxt;
   logic pslverr_r, pslverr_nxt;
   logic [atcs_pkg::CHAN_W-1:0] chan_r, chan_nxt;
   logic complete_r, complete_nxt;
   logic trig_sel_r, trig_sel_nxt;
   logic cmp_en_r, cmp_en_nxt;
   logic cmp_gt_r, cmp_gt_nxt;
   logic [RES_W-1:0] cmp_val_r, cmp_val_nxt;
   logic [atcs_pkg::IRQ_W-1:0] stat_r, stat_nxt, mask_r, mask_nxt, stat_set;
   logic irq_r, irq_nxt;
   logic hwt_meta_r, hwt_sync_r, hwt_prev_r;

   logic setup, xfer, wr, rd, mapped;
   logic hit_sc1, hit_sc2, hit_res, hit_cmp, hit_stat, hit_mask;
   logic sc1_wr, chan_off_wr, res_rd, hw_edge, sw_start, hw_start;
   logic conv_end, compare_true, complete_set;
   logic [RES_W-1:0] fifo_head;
   logic fifo_empty, fifo_full, fifo_ovwr;
   logic [31:0] rd_mux;

   // ---------------------------------------------------------------
   // bus decode
   // ---------------------------------------------------------------
   assign setup = psel && !penable;
   assign xfer = psel && penable && pready_r;
   assign wr = xfer && pwrite;
   assign rd = xfer && !pwrite;
   assign hit_sc1 = (paddr == atcs_pkg::ADDR_SC1);
   assign hit_sc2 = (paddr == atcs_pkg::ADDR_SC2);
   assign hit_res = (paddr == atcs_pkg::ADDR_RESULT);
   assign hit_cmp = (paddr == atcs_pkg::ADDR_CMP);
   assign hit_stat = (paddr == atcs_pkg::ADDR_IRQ_STAT);
   assign hit_mask = (paddr == atcs_pkg::ADDR_IRQ_MASK);
   assign mapped = hit_sc1 || hit_sc2 || hit_res || hit_cmp || hit_stat || hit_mask;
   assign sc1_wr = wr && hit_sc1;
   assign chan_off_wr = sc1_wr && (pwdata[atcs_pkg::CHAN_W-1:0] == atcs_pkg::CHAN_OFF);
   assign res_rd = rd && hit_res;

   // ---------------------------------------------------------------
   // trigger sources
   // ---------------------------------------------------------------
   assign hw_edge = hwt_sync_r && !hwt_prev_r;
   assign sw_start = sc1_wr && !chan_off_wr && !trig_sel_r;
   // a channel-off write in the same cycle beats a hardware edge
   assign hw_start = hw_edge && trig_sel_r
                     && (chan_r != atcs_pkg::CHAN_OFF)
                     && !chan_off_wr;

   // ---------------------------------------------------------------
   // compare direction
   // ---------------------------------------------------------------
   assign compare_true = cmp_gt_r ? (sample_value >= cmp_val_r)
                                  : (sample_value < cmp_val_r);
   assign complete_set = conv_end && (!cmp_en_r || compare_true);

   // failed compares never reach the queue
   atcs_result_fifo #(
      .W(RES_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clock(clock),
      .srst(srst),
      .flush(chan_off_wr),
      .push(complete_set),
      .push_data(sample_value),
      .pop(res_rd),
      .head(fifo_head),
      .empty(fifo_empty),
      .full(fifo_full),
      .overwrite(fifo_ovwr)
   );

   // ---------------------------------------------------------------
   // conversion engine
   // ---------------------------------------------------------------
   always_comb
   begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      start_nxt = 1'b0;
      conv_end = 1'b0;
      conv_chan_nxt = conv_chan_r;
      case (state_r)
         atcs_pkg::ATCS_IDLE:
         begin
            if (sw_start || hw_start)
            begin
               state_nxt = atcs_pkg::ATCS_CONV;
               cnt_nxt = '0;
               start_nxt = 1'b1;
               conv_chan_nxt = sw_start ? pwdata[atcs_pkg::CHAN_W-1:0] : chan_r;
            end
         end
         atcs_pkg::ATCS_CONV:
         begin
            if (sc1_wr)
            begin
               // abort; restart only on software trigger with a live channel
               state_nxt = sw_start ? atcs_pkg::ATCS_CONV : atcs_pkg::ATCS_IDLE;
               cnt_nxt = '0;
               start_nxt = sw_start;
               conv_chan_nxt = sw_start ? pwdata[atcs_pkg::CHAN_W-1:0] : conv_chan_r;
            end
            else if (cnt_r == CNT_LAST)
            begin
               state_nxt = atcs_pkg::ATCS_IDLE;
               conv_end = 1'b1;
            end
            else
               cnt_nxt = cnt_r + 1'b1;
         end
         default:
         begin
            state_nxt = atcs_pkg::ATCS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         state_r <= atcs_pkg::ATCS_IDLE;
         cnt_r <= '0;
         start_r <= 1'b0;
         conv_chan_r <= atcs_pkg::RST_CHAN;
         hwt_meta_r <= 1'b0;
         hwt_sync_r <= 1'b0;
         hwt_prev_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         start_r <= start_nxt;
         conv_chan_r <= conv_chan_nxt;
         hwt_meta_r <= hardware_trigger_in;
         hwt_sync_r <= hwt_meta_r;
         hwt_prev_r <= hwt_sync_r;
      end
   end

   // ---------------------------------------------------------------
   // read mux
   // ---------------------------------------------------------------
   always_comb
   begin
      rd_mux = 32'h0;
      if (hit_sc1)
         rd_mux[7:0] = {complete_r, 2'h0, chan_r};
      else if (hit_sc2)
         rd_mux[7:0] = {state_r == atcs_pkg::ATCS_CONV,
                        trig_sel_r, cmp_en_r, cmp_gt_r,
                        fifo_empty,
                        fifo_full,
                        2'h0};
      else if (hit_res)
         rd_mux[RES_W-1:0] = fifo_head;
      else if (hit_cmp)
         rd_mux[RES_W-1:0] = cmp_val_r;
      else if (hit_stat)
         rd_mux[atcs_pkg::IRQ_W-1:0] = stat_r;
      else if (hit_mask)
         rd_mux[atcs_pkg::IRQ_W-1:0] = mask_r;
   end

   // ---------------------------------------------------------------
   // bus slave and registers
   // ---------------------------------------------------------------
   always_comb
   begin
      pready_nxt = setup;
      pslverr_nxt = setup && !mapped;
      // read data frozen at setup, shown in the access cycle
      prdata_nxt = (setup && !pwrite) ? rd_mux : prdata_r;
      chan_nxt = chan_r;
      trig_sel_nxt = trig_sel_r;
      cmp_en_nxt = cmp_en_r;
      cmp_gt_nxt = cmp_gt_r;
      cmp_val_nxt = cmp_val_r;
      mask_nxt = mask_r;
      stat_set = '0;
      if (sc1_wr)
         chan_nxt = pwdata[atcs_pkg::CHAN_W-1:0];
      if (wr && hit_sc2)
      begin
         // active, empty and full bits take no write
         trig_sel_nxt = pwdata[atcs_pkg::BIT_TRIG];
         cmp_en_nxt = pwdata[atcs_pkg::BIT_CMP_EN];
         cmp_gt_nxt = pwdata[atcs_pkg::BIT_CMP_GT];
      end
      if (wr && hit_cmp)
         cmp_val_nxt = pwdata[RES_W-1:0];
      if (wr && hit_mask)
         mask_nxt = pwdata[atcs_pkg::IRQ_W-1:0];
      // completion flag: set wins over clear
      if (complete_set)
         complete_nxt = 1'b1;
      else if (sc1_wr || res_rd)
         complete_nxt = 1'b0;
      else
         complete_nxt = complete_r;
      stat_set[atcs_pkg::IRQ_DONE] = complete_set;
      stat_set[atcs_pkg::IRQ_OVWR] = fifo_ovwr;
      stat_nxt = stat_r | stat_set;
      if (wr && hit_stat)
         stat_nxt = (stat_r & ~pwdata[atcs_pkg::IRQ_W-1:0]) | stat_set;
      irq_nxt = |(stat_nxt & mask_nxt);
   end

   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0;
         chan_r <= atcs_pkg::RST_CHAN;
         complete_r <= 1'b0;
         trig_sel_r <= atcs_pkg::RST_SC2[atcs_pkg::BIT_TRIG];
         cmp_en_r <= atcs_pkg::RST_SC2[atcs_pkg::BIT_CMP_EN];
         cmp_gt_r <= atcs_pkg::RST_SC2[atcs_pkg::BIT_CMP_GT];
         cmp_val_r <= '0;
         stat_r <= '0;
         mask_r <= '0;
         irq_r <= 1'b0;
      end
      else
      begin
         pready_r <= pready_nxt;
         pslverr_r <= pslverr_nxt;
         prdata_r <= prdata_nxt;
         chan_r <= chan_nxt;
         complete_r <= complete_nxt;
         trig_sel_r <= trig_sel_nxt;
         cmp_en_r <= cmp_en_nxt;
         cmp_gt_r <= cmp_gt_nxt;
         cmp_val_r <= cmp_val_nxt;
         stat_r <= stat_nxt;
         mask_r <= mask_nxt;
         irq_r <= irq_nxt;
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign conv_start = start_r;
   assign conv_channel = conv_chan_r;
   assign irq = irq_r;

endmodule
`default_nettype wire

// ==== testbench/atcs_front_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module atcs_front_model #(
   parameter int CONV_CYCLES = 20
) (
   input wire logic clock,
   input wire logic conv_start,
   input wire logic fire,
   input wire logic [11:0] next_sample,
   output logic [11:0] sample_value,
   output logic hardware_trigger_in
);
   logic [11:0] held_r = 12'h0;
   int cnt_r = 0;
   int hw_r = 0;
   // value holds only while converting, else it shows the inverted value
   always @(posedge clock)
   begin
      if (conv_start)
      begin
         held_r <= next_sample;
         cnt_r <= CONV_CYCLES + 1;
      end
      else if (cnt_r > 0)
         cnt_r <= cnt_r - 1;
      if (fire)
         hw_r <= 4;
      else if (hw_r > 0)
         hw_r <= hw_r - 1;
   end
   assign sample_value = (cnt_r > 0) ? held_r : ~held_r;
   assign hardware_trigger_in = (hw_r > 0);
endmodule
`default_nettype wire

// ==== testbench/atcs_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module atcs_chk (
   input wire logic clock,
   input wire logic srst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [atcs_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic hardware_trigger_in,
   input wire logic conv_start,
   input wire logic [atcs_pkg::CHAN_W-1:0] conv_channel
);
   logic trig_r;
   logic trig_nxt;
   logic wr_done;
   logic sc1_wr;
   logic sc2_rd;
   assign wr_done = psel && penable && pready && pwrite;
   assign sc1_wr = wr_done && paddr == atcs_pkg::ADDR_SC1;
   assign sc2_rd = pready && !pwrite && paddr == atcs_pkg::ADDR_SC2;
   // -----------------------------------------------
   // shadow of the trigger select bit
   // -----------------------------------------------
   always_comb
   begin
      trig_nxt = trig_r;
      if (wr_done && paddr == atcs_pkg::ADDR_SC2)
         trig_nxt = pwdata[atcs_pkg::BIT_TRIG];
   end
   always_ff @(posedge clock)
   begin
      if (srst)
         trig_r <= 1'b0;
      else
         trig_r <= trig_nxt;
   end
   default clocking @(posedge clock); endclocking
   default disable iff (srst);
   a_ready_after_setup: assert property (psel && !penable |=> pready)
      else $error("no answer after setup");
   a_ready_in_access: assert property (pready |-> psel && penable)
      else $error("answer outside access");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("error without answer");
   a_sc2_reserved: assert property (sc2_rd |-> prdata[1:0] == 2'h0 && prdata[31:8] == 24'h0)
      else $error("reserved bits not zero");
   a_queue_flags: assert property (sc2_rd |-> !(prdata[3] && prdata[2]))
      else $error("queue empty and full together");
   a_sw_start: assert property (sc1_wr && !trig_r && pwdata[4:0] != 5'h1f
      |=> conv_start && conv_channel == $past(pwdata[4:0]))
      else $error("software start missing");
   a_off_stops: assert property (sc1_wr && pwdata[4:0] == 5'h1f |=> !conv_start [*2])
      else $error("start with channel off");
   a_hw_sel_quiet: assert property ((!hardware_trigger_in) [*5] ##0 (sc1_wr && trig_r)
      |=> !conv_start)
      else $error("software start in hardware mode");
   a_start_pulse: assert property (conv_start |=> !conv_start)
      else $error("start pulse too long");
endmodule
bind atcs_top atcs_chk atcs_chk_inst (.clock(clock), .srst(srst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .hardware_trigger_in(hardware_trigger_in),
   .conv_start(conv_start), .conv_channel(conv_channel));
`default_nettype wire

// ==== testbench/test_adc_trigger_compare_status.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_adc_trigger_compare_status;
   localparam int CONV = 4;
   logic clock = 1'b0;
   logic srst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic hw;
   logic [11:0] smp;
   logic [11:0] nxt = 12'h0;
   logic fire = 1'b0;
   logic conv_start;
   logic [4:0] chan;
   logic irq;
   int errors = 0;
   int n_compared = 0;
   logic [31:0] seed = 32'h5776;
   logic [31:0] q;
   logic err;
   logic p;
   logic [11:0] s;
   int i;
   atcs_top #(.CONV_CYCLES(CONV)) atcs_top_inst (.clock(clock), .srst(srst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .hardware_trigger_in(hw), .sample_value(smp),
      .conv_start(conv_start), .conv_channel(chan), .irq(irq));
   atcs_front_model #(.CONV_CYCLES(CONV)) atcs_front_model_inst (.clock(clock),
      .conv_start(conv_start), .fire(fire), .next_sample(nxt), .sample_value(smp),
      .hardware_trigger_in(hw));
   initial
   begin
      forever #2.5 clock = ~clock;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], 1'b0} ^ (x[31] ? 32'h000000c5 : 32'h0);
   endfunction
   function automatic logic [31:0] sc2(input logic [2:0] c, input logic a, e, f);
      return {24'h0, a, c, e, f, 2'h0};
   endfunction
   function automatic logic pass(input logic ce, gt, input logic [11:0] r, c);
      return !ce || (gt ? r >= c : r < c);
   endfunction
   task automatic chk(input logic [31:0] got, exp);
      n_compared++;
      if (got !== exp)
      begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic close_out;
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge clock);
         k++;
      end
      while (pready !== 1'b1 && k < 20);
      if (pready !== 1'b1)
      begin
         errors++;
         $display("mismatch at %0t: no bus answer", $time);
         close_out();
      end
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(q, e);
   endtask
   task automatic conv(input logic [4:0] c, input logic [11:0] v);
      nxt <= v;
      wr(atcs_pkg::ADDR_SC1, {27'h0, c});
      repeat (CONV + 4) @(posedge clock);
   endtask
   initial
   begin
      repeat (5) @(posedge clock);
      srst <= 1'b0;
      rd(atcs_pkg::ADDR_SC2, 32'h08);
      rd(atcs_pkg::ADDR_SC1, 32'h1f);
      for (i = 0; i < 8; i++)
      begin
         seed = lfsr(seed);
         wr(atcs_pkg::ADDR_SC2, {24'h0, seed[7:0]});
         rd(atcs_pkg::ADDR_SC2, sc2(seed[6:4], 1'b0, 1'b1, 1'b0));
      end
      apb(1'b0, 12'hffc, 32'h0);
      chk({31'h0, err}, 32'h1);
      chk(q, 32'h0);
      wr(atcs_pkg::ADDR_IRQ_MASK, 32'h3);
      wr(atcs_pkg::ADDR_SC2, 32'h0);
      seed = lfsr(seed);
      nxt <= seed[11:0];
      wr(atcs_pkg::ADDR_SC1, 32'h3);
      rd(atcs_pkg::ADDR_SC2, sc2(3'h0, 1'b1, 1'b1, 1'b0));
      repeat (CONV + 4) @(posedge clock);
      chk({31'h0, irq}, 32'h1);
      rd(atcs_pkg::ADDR_SC2, sc2(3'h0, 1'b0, 1'b0, 1'b0));
      rd(atcs_pkg::ADDR_IRQ_STAT, 32'h1);
      wr(atcs_pkg::ADDR_IRQ_STAT, 32'h1);
      repeat (2) @(posedge clock);
      chk({31'h0, irq}, 32'h0);
      rd(atcs_pkg::ADDR_RESULT, {20'h0, seed[11:0]});
      wr(atcs_pkg::ADDR_CMP, 32'h400);
      for (i = 0; i < 5; i++)
      begin
         s = i[0] ? 12'h400 : 12'h3ff;
         p = pass(i < 4, i[1], s, 12'h400);
         wr(atcs_pkg::ADDR_SC2, {26'h0, i < 4, i[1], 4'h0});
         conv(5'h5, s);
         rd(atcs_pkg::ADDR_SC1, {24'h0, p, 7'h05});
         rd(atcs_pkg::ADDR_SC2, sc2({1'b0, i < 4, i[1]}, 1'b0, !p, 1'b0));
         wr(atcs_pkg::ADDR_SC1, 32'h1f);
      end
      wr(atcs_pkg::ADDR_SC2, 32'h0);
      wr(atcs_pkg::ADDR_IRQ_STAT, 32'h3);
      for (i = 0; i < 5; i++)
      begin
         conv(5'h1, 12'h100 + i[11:0]);
         if (i == 2)
            rd(atcs_pkg::ADDR_SC2, sc2(3'h0, 1'b0, 1'b0, 1'b0));
         if (i == 3)
            rd(atcs_pkg::ADDR_SC2, sc2(3'h0, 1'b0, 1'b0, 1'b1));
      end
      rd(atcs_pkg::ADDR_IRQ_STAT, 32'h3);
      rd(atcs_pkg::ADDR_RESULT, 32'h101);
      wr(atcs_pkg::ADDR_SC1, 32'h3);
      wr(atcs_pkg::ADDR_SC1, 32'h4);
      rd(atcs_pkg::ADDR_SC2, sc2(3'h0, 1'b1, 1'b0, 1'b0));
      chk({27'h0, chan}, 32'h4);
      wr(atcs_pkg::ADDR_SC1, 32'h3);
      wr(atcs_pkg::ADDR_SC1, 32'h1f);
      rd(atcs_pkg::ADDR_SC2, sc2(3'h0, 1'b0, 1'b1, 1'b0));
      rd(atcs_pkg::ADDR_SC1, 32'h1f);
      wr(atcs_pkg::ADDR_SC2, 32'h40);
      conv(5'h2, 12'h055);
      rd(atcs_pkg::ADDR_SC2, sc2(3'h4, 1'b0, 1'b1, 1'b0));
      @(posedge clock);
      fire <= 1'b1;
      @(posedge clock);
      fire <= 1'b0;
      for (i = 0; i < 20 && conv_start !== 1'b1; i++)
         @(posedge clock);
      chk({31'h0, conv_start}, 32'h1);
      chk({27'h0, chan}, 32'h2);
      repeat (CONV + 4) @(posedge clock);
      rd(atcs_pkg::ADDR_SC2, sc2(3'h4, 1'b0, 1'b0, 1'b0));
      close_out();
   end
endmodule
`default_nettype wire
